// ==== verilog/dual_uart_pkg.sv ====
/*
  shared constants and types for the two-channel uart host bus port and
  the host-side controller that drives it.
  assumes: one 100 MHz clock on both ends, bus pins synchronous to it.
*/
package dual_uart_pkg;

  // ----------------------------------------------------------------------
  // bus widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W    = 3;
  localparam int DATA_W    = 8;
  localparam int NUM_CHAN  = 2;
  localparam int NUM_REG   = 8;

  // ----------------------------------------------------------------------
  // device register layout
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] MODEM_IDX    = 3'h4;  // modem control register
  localparam int                IRQ_OE_BIT   = 3;     // interrupt output enable
  localparam logic [ADDR_W-1:0] PWR_IDX      = 3'h7;  // power control, channel A
  localparam int                PWR_OSC_BIT  = 0;
  localparam int                PWR_PUMP_BIT = 1;
  localparam int                PWR_WAKE_BIT = 7;
  localparam logic [DATA_W-1:0] REG_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] BUS_IDLE     = 8'hFF;

  // ----------------------------------------------------------------------
  // host controller register map
  // ----------------------------------------------------------------------
  localparam logic [2:0] HREG_TARGET = 3'h0;  // bit3 channel, bits 2:0 register
  localparam logic [2:0] HREG_WDATA  = 3'h1;
  localparam logic [2:0] HREG_CTRL   = 3'h2;  // bit0 start read, bit1 start write
  localparam logic [2:0] HREG_STATUS = 3'h3;  // bit0 busy, bit1 done, bit2 irq
  localparam logic [2:0] HREG_RDATA  = 3'h4;
  localparam logic [2:0] HREG_CONFIG = 3'h5;  // bit0 strobe style, bit1 isolate, bit2 autosleep
  localparam int CTRL_RD_BIT   = 0;
  localparam int CTRL_WR_BIT   = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_IRQ_BIT  = 2;
  localparam int CFG_STYLE_BIT = 0;
  localparam int CFG_ISO_BIT   = 1;
  localparam int CFG_AUTO_BIT  = 2;
  localparam logic [DATA_W-1:0] CFG_RESET = 8'h01;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS     = 40;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_PARTIAL, PWR_FULL, PWR_SAVE} pwr_mode_t;
  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} host_state_t;

endpackage : dual_uart_pkg

// ==== verilog/dual_uart_bus_if.sv ====
/*
  pins between the host processor and the two-channel uart bus port.
  assumes: the data bus and interrupt pins are resolved here from the
  enables; undriven data reads BUS_IDLE, the open-drain line is pulled up.
*/
`timescale 1ns/10ps
interface dual_uart_bus_if;
  import dual_uart_pkg::*;

  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] hostData;
  logic              hostDataOe;
  logic [DATA_W-1:0] devData;
  logic              devDataOe;
  logic              readStrobeN;
  logic              writeStrobeN;
  logic              chanASelectN;
  logic              chanBSelectN;
  logic              strobeStyle;
  logic              busIsolateIn;
  logic              pumpAutosleepIn;
  logic              chanAIrqOut;
  logic              chanAIrqOe;
  logic              chanBIrqOut;
  logic              chanBIrqOe;
  logic [DATA_W-1:0] dataBus;
  logic              irqAPin;
  logic              irqBPin;

  // ----------------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------------
  assign dataBus = devDataOe ? devData : (hostDataOe ? hostData : BUS_IDLE);
  assign irqAPin = chanAIrqOe ? chanAIrqOut : !strobeStyle;
  assign irqBPin = chanBIrqOe ? chanBIrqOut : 1'b0;

  modport device (
    input  regAddr, dataBus, readStrobeN, writeStrobeN, chanASelectN, chanBSelectN,
    input  strobeStyle, busIsolateIn, pumpAutosleepIn,
    output devData, devDataOe, chanAIrqOut, chanAIrqOe, chanBIrqOut, chanBIrqOe
  );

  modport host (
    output regAddr, hostData, hostDataOe, readStrobeN, writeStrobeN, chanASelectN,
    output chanBSelectN, strobeStyle, busIsolateIn, pumpAutosleepIn,
    input  dataBus, irqAPin, irqBPin
  );

endinterface : dual_uart_bus_if

// ==== verilog/dual_uart_bus_port.sv ====
/*
  device end: host bus port of a two-channel uart, with its register
  storage, interrupt pin drive and power-mode control.
  assumes: bus pins are synchronous to sys_clk; the uart cores feed
  uartIrq and rxActivity; the interface resolves the shared pins.
*/
`timescale 1ns/10ps
module dual_uart_bus_port
  import dual_uart_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // host bus
  dual_uart_bus_if.device            bus,
  // uart cores
  input  wire logic [NUM_CHAN-1:0]   uartIrq,
  input  wire logic [NUM_CHAN-1:0]   rxActivity,
  // power pins
  input  wire logic                  oscSleepIn,
  input  wire logic                  pumpSleepIn,
  output logic                       oscRun,
  output logic                       pumpRun,
  output pwr_mode_t                  powerMode,
  output logic                       wakeFlag
);
  import dual_uart_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [NUM_CHAN-1:0][NUM_REG-1:0][DATA_W-1:0] regFile;
    logic                                         rdAct;
    logic                                         wrAct;
    logic                                         chan;
    logic [ADDR_W-1:0]                            addr;
    logic [DATA_W-1:0]                            wrByte;
    logic [DATA_W-1:0]                            devData;
    logic                                         devDataOe;
    logic                                         irqAOut;
    logic                                         irqAOe;
    logic                                         irqBOut;
    logic                                         irqBOe;
    logic                                         sleeping;
    logic                                         wakeFlag;
    logic                                         oscRun;
    logic                                         pumpRun;
    pwr_mode_t                                    mode;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic              sel;
    logic              chanNow;
    logic              rdAct;
    logic              wrAct;
    logic              oscStop;
    logic              pumpStop;
    logic              sleepNow;
    logic [DATA_W-1:0] pwrReg;
    logic              irqA;
    logic              irqB;
    sel      = 1'b0;
    chanNow  = 1'b0;
    rdAct    = 1'b0;
    wrAct    = 1'b0;
    oscStop  = 1'b0;
    pumpStop = 1'b0;
    sleepNow = 1'b0;
    pwrReg   = s.regFile[0][PWR_IDX];
    irqA     = 1'b0;
    irqB     = 1'b0;
    next_s   = s;

    // decode of the two bus styles
    if (bus.strobeStyle)
    begin
      sel     = !bus.chanASelectN || !bus.chanBSelectN;
      chanNow = !bus.chanBSelectN;
      rdAct   = sel && !bus.readStrobeN;
      wrAct   = sel && !bus.writeStrobeN;
    end
    else
    begin
      sel     = !bus.chanASelectN;
      chanNow = bus.chanBSelectN;
      rdAct   = sel && bus.writeStrobeN;
      wrAct   = sel && !bus.writeStrobeN;
    end

    // while asleep with isolation up, the bus looks idle to the core
    if (bus.busIsolateIn && s.sleeping)
    begin
      rdAct = 1'b0;
      wrAct = 1'b0;
    end
    next_s.rdAct = rdAct;
    next_s.wrAct = wrAct;

    // read: byte launched at the start, bus released at the end
    if (rdAct && !s.rdAct)
    begin
      next_s.chan      = chanNow;
      next_s.addr      = bus.regAddr;
      next_s.devDataOe = 1'b1;
      next_s.devData   = s.regFile[chanNow][bus.regAddr];
      if (!chanNow && bus.regAddr == PWR_IDX)
      begin
        next_s.devData[PWR_WAKE_BIT] = s.wakeFlag;
      end
    end
    else if (!rdAct && s.rdAct)
    begin
      next_s.devDataOe = 1'b0;
      if (!s.chan && s.addr == PWR_IDX)
      begin
        next_s.wakeFlag = 1'b0;
      end
    end

    // write: address caught at the start, last sampled byte stored at the end
    if (wrAct && !s.wrAct)
    begin
      next_s.chan = chanNow;
      next_s.addr = bus.regAddr;
    end
    if (wrAct)
    begin
      next_s.wrByte = bus.dataBus;
    end
    else if (s.wrAct)
    begin
      next_s.regFile[s.chan][s.addr] = s.wrByte;
      if (!s.chan && s.addr == PWR_IDX)
      begin
        next_s.regFile[0][PWR_IDX][PWR_WAKE_BIT] = 1'b0;
      end
    end

    // receivers stay alive; activity on either line drops software sleep
    if (s.sleeping && |rxActivity)
    begin
      next_s.regFile[0][PWR_IDX][PWR_OSC_BIT]  = 1'b0;
      next_s.regFile[0][PWR_IDX][PWR_PUMP_BIT] = 1'b0;
    end

    // power modes from pins or register bits
    oscStop  = oscSleepIn || pwrReg[PWR_OSC_BIT];
    pumpStop = pumpSleepIn || pwrReg[PWR_PUMP_BIT]
               || (bus.pumpAutosleepIn && oscStop);
    sleepNow = oscStop || pumpStop;
    next_s.oscRun   = !oscStop;
    next_s.pumpRun  = !pumpStop;
    next_s.sleeping = sleepNow;
    if (!sleepNow)
    begin
      next_s.mode = PWR_ACTIVE;
    end
    else if (bus.busIsolateIn)
    begin
      next_s.mode = PWR_SAVE;
    end
    else if (oscStop && pumpStop)
    begin
      next_s.mode = PWR_FULL;
    end
    else
    begin
      next_s.mode = PWR_PARTIAL;
    end
    // set wins over the clear by a read of the power register
    if (s.sleeping && !sleepNow)
    begin
      next_s.wakeFlag = 1'b1;
    end

    // interrupt pins
    irqA = uartIrq[0] || s.wakeFlag;
    irqB = uartIrq[1];
    if (bus.strobeStyle)
    begin
      next_s.irqAOut = irqA;
      next_s.irqAOe  = s.regFile[0][MODEM_IDX][IRQ_OE_BIT];
      next_s.irqBOut = irqB;
      next_s.irqBOe  = s.regFile[1][MODEM_IDX][IRQ_OE_BIT];
    end
    else
    begin
      // open drain: only ever pulls low, and only with the enable bit clear
      next_s.irqAOut = 1'b0;
      next_s.irqAOe  = (irqA || irqB) && !s.regFile[0][MODEM_IDX][IRQ_OE_BIT];
      next_s.irqBOut = 1'b0;
      next_s.irqBOe  = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s         <= '0;
      s.regFile <= {(NUM_CHAN * NUM_REG){REG_RESET}};
      s.devData <= BUS_IDLE;
      s.oscRun  <= 1'b1;
      s.pumpRun <= 1'b1;
      s.mode    <= PWR_ACTIVE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign bus.devData     = s.devData;
  assign bus.devDataOe   = s.devDataOe;
  assign bus.chanAIrqOut = s.irqAOut;
  assign bus.chanAIrqOe  = s.irqAOe;
  assign bus.chanBIrqOut = s.irqBOut;
  assign bus.chanBIrqOe  = s.irqBOe;
  assign oscRun          = s.oscRun;
  assign pumpRun         = s.pumpRun;
  assign powerMode       = s.mode;
  assign wakeFlag        = s.wakeFlag;

endmodule : dual_uart_bus_port

// ==== verilog/dual_uart_host_ctrl.sv ====
/*
  host end: runs single register reads and writes on the uart bus port
  in either bus style, ordered by software through a small register port.
  assumes: one software access per cycle, read data taken the cycle after.
*/
`timescale 1ns/10ps
module dual_uart_host_ctrl
  import dual_uart_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // software port
  input  wire logic [2:0]        swAddr,
  input  wire logic [DATA_W-1:0] swWdata,
  input  wire logic              swWrite,
  input  wire logic              swRead,
  output logic      [DATA_W-1:0] swRdata,
  // uart bus
  dual_uart_bus_if.host          bus
);
  import dual_uart_pkg::*;

  typedef struct packed {
    host_state_t       state;
    logic [2:0]        cnt;
    logic [3:0]        target;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] cfg;
    logic              isWrite;
    logic              busy;
    logic              done;
    logic              irqSeen;
    logic [DATA_W-1:0] swRdata;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] hostData;
    logic              hostDataOe;
    logic              rdN;
    logic              wrN;
    logic              csAN;
    logic              csBN;
  } host_reg_t;

  host_reg_t s;
  host_reg_t next_s;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic style;
    style  = s.cfg[CFG_STYLE_BIT];
    next_s = s;
    next_s.irqSeen = style ? (bus.irqAPin || bus.irqBPin) : !bus.irqAPin;

    // software port
    next_s.swRdata = '0;
    if (swRead)
    begin
      unique case (swAddr)
        HREG_TARGET: next_s.swRdata = {4'h0, s.target};
        HREG_WDATA:  next_s.swRdata = s.wdata;
        HREG_STATUS: next_s.swRdata = {5'h00, s.irqSeen, s.done, s.busy};
        HREG_RDATA:  next_s.swRdata = s.rdata;
        HREG_CONFIG: next_s.swRdata = s.cfg;
        default:     next_s.swRdata = '0;
      endcase
      if (swAddr == HREG_STATUS)
      begin
        next_s.done = 1'b0;
      end
    end
    if (swWrite && !s.busy)
    begin
      unique case (swAddr)
        HREG_TARGET: next_s.target = swWdata[3:0];
        HREG_WDATA:  next_s.wdata  = swWdata;
        HREG_CONFIG: next_s.cfg    = swWdata;
        default:     ;
      endcase
    end

    // bus sequence
    unique case (s.state)
      H_IDLE:
      begin
        if (swWrite && swAddr == HREG_CTRL && !s.busy
            && (swWdata[CTRL_RD_BIT] || swWdata[CTRL_WR_BIT]))
        begin
          next_s.isWrite    = swWdata[CTRL_WR_BIT];
          next_s.busy       = 1'b1;
          next_s.regAddr    = s.target[2:0];
          next_s.hostData   = s.wdata;
          next_s.hostDataOe = swWdata[CTRL_WR_BIT];
          if (style)
          begin
            next_s.csAN = s.target[3];
            next_s.csBN = !s.target[3];
          end
          else
          begin
            next_s.csBN = s.target[3];
            next_s.wrN  = !swWdata[CTRL_WR_BIT];
          end
          next_s.state = H_SETUP;
        end
      end
      H_SETUP:
      begin
        if (style)
        begin
          next_s.rdN = s.isWrite;
          next_s.wrN = !s.isWrite;
        end
        else
        begin
          next_s.csAN = 1'b0;
        end
        next_s.cnt   = 3'(STROBE_CYC - 1);
        next_s.state = H_STROBE;
      end
      H_STROBE:
      begin
        if (s.cnt == '0)
        begin
          // sample just before the strobe rises
          if (!s.isWrite)
          begin
            next_s.rdata = bus.dataBus;
          end
          if (style)
          begin
            next_s.rdN = 1'b1;
            next_s.wrN = 1'b1;
          end
          else
          begin
            next_s.csAN = 1'b1;
          end
          next_s.state = H_HOLD;
        end
        else
        begin
          next_s.cnt = s.cnt - 3'h1;
        end
      end
      H_HOLD:
      begin
        // address and data held one cycle past the strobe
        next_s.csAN       = 1'b1;
        next_s.csBN       = 1'b1;
        next_s.wrN        = 1'b1;
        next_s.hostDataOe = 1'b0;
        next_s.busy       = 1'b0;
        next_s.done       = 1'b1;
        next_s.state      = H_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s       <= '0;
      s.state <= H_IDLE;
      s.cfg   <= CFG_RESET;
      s.rdN   <= 1'b1;
      s.wrN   <= 1'b1;
      s.csAN  <= 1'b1;
      s.csBN  <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign swRdata             = s.swRdata;
  assign bus.regAddr         = s.regAddr;
  assign bus.hostData        = s.hostData;
  assign bus.hostDataOe      = s.hostDataOe;
  assign bus.readStrobeN     = s.rdN;
  assign bus.writeStrobeN    = s.wrN;
  assign bus.chanASelectN    = s.csAN;
  assign bus.chanBSelectN    = s.csBN;
  assign bus.strobeStyle     = s.cfg[CFG_STYLE_BIT];
  assign bus.busIsolateIn    = s.cfg[CFG_ISO_BIT];
  assign bus.pumpAutosleepIn = s.cfg[CFG_AUTO_BIT];

endmodule : dual_uart_host_ctrl

// ==== sim/dual_uart_port_props.sv ====
/*
  checker for the pins between the host controller and the uart bus port.
  assumes: instantiated beside the interface, one clock domain.
*/
`timescale 1ns/10ps
module dual_uart_port_props
(
  // clock and reset
  input logic                            sys_clk,
  input logic                            rst_n,
  // bus pins
  input logic [dual_uart_pkg::ADDR_W-1:0] regAddr,
  input logic                            hostDataOe,
  input logic                            devDataOe,
  input logic                            readStrobeN,
  input logic                            writeStrobeN,
  input logic                            chanASelectN,
  input logic                            chanBSelectN,
  input logic                            strobeStyle,
  input logic                            busIsolateIn,
  input logic                            chanAIrqOut,
  input logic                            chanAIrqOe,
  input logic                            chanBIrqOe
);
  import dual_uart_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------------
  // bus ownership and timing
  // ----------------------------------------------------------------------
  one_driver_a: assert property (!(devDataOe && hostDataOe))
    else $error("data bus driven from both ends");
  read_drive_a: assert property (strobeStyle && !busIsolateIn && $fell(readStrobeN) |-> ##[1:2] devDataOe)
    else $error("read strobe did not bring read data");
  strobe_len_a: assert property ($fell(readStrobeN) |-> ##1 !readStrobeN [*3] ##1 readStrobeN)
    else $error("read strobe width wrong");
  write_quiet_a: assert property (strobeStyle && $fell(writeStrobeN) |-> !devDataOe throughout !writeStrobeN [*4])
    else $error("device drove bus during write");
  line_write_a: assert property (!strobeStyle && $fell(chanASelectN) && !writeStrobeN |-> !devDataOe [*4])
    else $error("device drove bus during line style write");
  one_select_a: assert property (strobeStyle |-> chanASelectN || chanBSelectN)
    else $error("both channel selects low");
  addr_stable_a: assert property (strobeStyle && !(readStrobeN && writeStrobeN)
    && $past(!(readStrobeN && writeStrobeN)) |-> $stable(regAddr))
    else $error("address moved under strobe");
  // ----------------------------------------------------------------------
  // interrupt pins
  // ----------------------------------------------------------------------
  b_irq_off_a: assert property (!strobeStyle && !$past(strobeStyle) |-> !chanBIrqOe)
    else $error("channel B irq driven in line style");
  shared_irq_a: assert property (!strobeStyle && !$past(strobeStyle) && chanAIrqOe |-> !chanAIrqOut)
    else $error("shared irq driven high");
endmodule : dual_uart_port_props

// ==== sim/tb_top.sv ====
/*
  bench: host controller and bus port joined by their interface.
  assumes: package, interface and both design ends compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  import dual_uart_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  typedef struct {logic [7:0] cfg; logic [7:0] tgt; logic [7:0] dat;} row_t;
  logic              sys_clk     = 1'b0;
  logic              rst_n       = 1'b0;
  logic [2:0]        swAddr      = 3'h0;
  logic [DATA_W-1:0] swWdata     = 8'h00;
  logic              swWrite     = 1'b0;
  logic              swRead      = 1'b0;
  logic [DATA_W-1:0] swRdata;
  logic [1:0]        uartIrq     = 2'h0;
  logic [1:0]        rxActivity  = 2'h0;
  logic              oscSleepIn  = 1'b0;
  logic              pumpSleepIn = 1'b0;
  logic              oscRun;
  logic              pumpRun;
  pwr_mode_t         powerMode;
  logic              wakeFlag;
  logic [DATA_W-1:0] got;
  int                err_count   = 0;
  int                tests_run   = 0;
  // style, {channel, register}, byte
  row_t rows [4] = '{'{8'h01, 8'h01, 8'h5A}, '{8'h01, 8'h0E, 8'hA5}, '{8'h00, 8'h02, 8'hC3}, '{8'h00, 8'h0B, 8'h3C}};
  always #5 sys_clk = ~sys_clk;
  dual_uart_bus_if dual_uart_bus_if_i ();
  dual_uart_host_ctrl dual_uart_host_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .swAddr(swAddr), .swWdata(swWdata),
    .swWrite(swWrite), .swRead(swRead), .swRdata(swRdata), .bus(dual_uart_bus_if_i.host));
  dual_uart_bus_port dual_uart_bus_port_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(dual_uart_bus_if_i.device),
    .uartIrq(uartIrq), .rxActivity(rxActivity), .oscSleepIn(oscSleepIn), .pumpSleepIn(pumpSleepIn),
    .oscRun(oscRun), .pumpRun(pumpRun), .powerMode(powerMode), .wakeFlag(wakeFlag));
  dual_uart_port_props dual_uart_port_props_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(dual_uart_bus_if_i.regAddr), .hostDataOe(dual_uart_bus_if_i.hostDataOe),
    .devDataOe(dual_uart_bus_if_i.devDataOe), .readStrobeN(dual_uart_bus_if_i.readStrobeN),
    .writeStrobeN(dual_uart_bus_if_i.writeStrobeN), .chanASelectN(dual_uart_bus_if_i.chanASelectN),
    .chanBSelectN(dual_uart_bus_if_i.chanBSelectN), .strobeStyle(dual_uart_bus_if_i.strobeStyle),
    .busIsolateIn(dual_uart_bus_if_i.busIsolateIn), .chanAIrqOut(dual_uart_bus_if_i.chanAIrqOut),
    .chanAIrqOe(dual_uart_bus_if_i.chanAIrqOe), .chanBIrqOe(dual_uart_bus_if_i.chanBIrqOe));
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task check(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      err_count++;
    end
  endtask : check
  task sw_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    swAddr  <= a;
    swWdata <= d;
    swWrite <= 1'b1;
    @(posedge sys_clk);
    swWrite <= 1'b0;
  endtask : sw_wr
  task sw_rd(input logic [2:0] a);
    @(posedge sys_clk);
    swAddr <= a;
    swRead <= 1'b1;
    @(posedge sys_clk);
    swRead <= 1'b0;
    #1 got = swRdata;
  endtask : sw_rd
  // polling status clears done, so a stale done never ends the wait
  task xfer(input logic [7:0] t, input logic [7:0] d, input logic [7:0] c);
    sw_wr(HREG_TARGET, t);
    sw_wr(HREG_WDATA, d);
    sw_wr(HREG_CTRL, c);
    got = 8'h00;
    for (int i = 0; i < 30 && got[STAT_DONE_BIT] !== 1'b1; i++) sw_rd(HREG_STATUS);
    if (got[STAT_DONE_BIT] !== 1'b1)
    begin
      err_count++;
      end_sim();
    end
  endtask : xfer
  task rd_chk(input logic [7:0] t, input logic [7:0] e);
    xfer(t, 8'h00, 8'h01);
    sw_rd(HREG_RDATA);
    check(got, e);
  endtask : rd_chk
  task mode_chk(input pwr_mode_t m);
    repeat (3) @(posedge sys_clk);
    #1 check({6'h0, powerMode}, {6'h0, m});
  endtask : mode_chk
  // channel B pin must stay low in both styles: its enable bit is never set
  task pin_chk(input logic [7:0] cfg, input logic e);
    sw_wr(HREG_CONFIG, cfg);
    repeat (3) @(posedge sys_clk);
    #1 check({6'h0, dual_uart_bus_if_i.irqAPin, dual_uart_bus_if_i.irqBPin}, {6'h0, e, 1'b0});
  endtask : pin_chk
  task rst_chk;
    sw_rd(HREG_CONFIG);
    check(got, CFG_RESET);
    check({oscRun, pumpRun, wakeFlag, 3'h0, powerMode}, {6'h30, PWR_ACTIVE});
  endtask : rst_chk
  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rst_chk();
    // written in one style, read back in the other: channel mapping must agree
    for (int i = 0; i < 4; i++)
    begin
      sw_wr(HREG_CONFIG, rows[i].cfg);
      xfer(rows[i].tgt, rows[i].dat, 8'h02);
      sw_wr(HREG_CONFIG, rows[i].cfg ^ 8'h01);
      rd_chk(rows[i].tgt, rows[i].dat);
    end
    // interrupt pins in both styles, requests on both channels
    xfer(8'h04, 8'h08, 8'h02);
    @(posedge sys_clk);
    uartIrq <= 2'h3;
    pin_chk(8'h01, 1'b1);
    pin_chk(8'h00, 1'b1);
    xfer(8'h04, 8'h00, 8'h02);
    pin_chk(8'h00, 1'b0);
    // power modes by pin, autosleep, isolation
    @(posedge sys_clk);
    uartIrq    <= 2'h0;
    oscSleepIn <= 1'b1;
    mode_chk(PWR_PARTIAL);
    check({6'h0, oscRun, pumpRun}, 8'h01);
    sw_wr(HREG_CONFIG, 8'h05);
    mode_chk(PWR_FULL);
    check({6'h0, oscRun, pumpRun}, 8'h00);
    sw_wr(HREG_CONFIG, 8'h07);
    mode_chk(PWR_SAVE);
    xfer(8'h01, 8'hFF, 8'h02);
    @(posedge sys_clk);
    oscSleepIn <= 1'b0;
    sw_wr(HREG_CONFIG, 8'h01);
    mode_chk(PWR_ACTIVE);
    check({7'h0, wakeFlag}, 8'h01);
    rd_chk(8'h01, 8'h5A);
    rd_chk(8'h07, 8'h80);
    check({7'h0, wakeFlag}, 8'h00);
    // sleep by register, woken by receive activity
    xfer(8'h07, 8'h03, 8'h02);
    mode_chk(PWR_FULL);
    @(posedge sys_clk);
    rxActivity <= 2'h1;
    @(posedge sys_clk);
    rxActivity <= 2'h0;
    mode_chk(PWR_ACTIVE);
    // reset in mid-run: the wake flag and the stored bytes must go
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rst_chk();
    rd_chk(8'h01, REG_RESET);
    end_sim();
  end
endmodule : tb_top
